// File: hdl/cpwm_pkg.sv
// Shared constants, types and helpers of the capture/compare/PWM unit
package cpwm_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DUTY_W = 10;
  localparam int TB_W = 8;
  localparam int CMP_W = 16;
  localparam int PRE_W = 10;
  localparam int PSEL_W = 3;
  localparam int POST_W = 4;
  localparam int BYTE_W = 8;

  // ****************************************
  // Timing and reset values
  // ****************************************
  // Oscillator cycles per instruction cycle; clk_sys is the oscillator
  localparam logic [PRE_W-1:0] OSC_PER_INSTR = 10'h004;
  localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
  localparam logic [TB_W-1:0] TB_RESET = 8'h00;
  localparam logic [TB_W-1:0] TB_STEP = 8'h01;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;
  localparam logic [POST_W-1:0] POST_RESET = 4'h0;
  localparam logic [POST_W-1:0] POST_STEP = 4'h1;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic DIR_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [BYTE_W-1:0] CTRL_ALL_ZERO = 8'h00;

  // ****************************************
  // Mode field encodings
  // ****************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE_CLR = 4'h1;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_PULSE = 4'ha;
  localparam logic [3:0] MODE_PULSE_CLR = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  typedef enum logic [1:0] {
    CPWM_OFF,
    CPWM_CAPTURE,
    CPWM_COMPARE,
    CPWM_PWM
  } cpwm_mode_t;

  // ****************************************
  // Register images
  // ****************************************
  typedef struct packed {
    logic enable;
    logic spare;
    logic out_status;
    logic alignment_select;
    logic [3:0] mode;
  } cpwm_ctrl_t;

  typedef struct packed {
    logic on;
    logic [PSEL_W-1:0] prescale_select;
    logic [POST_W-1:0] postscale;
  } cpwm_tb_ctrl_t;

  typedef struct packed {
    logic [BYTE_W-1:0] high_byte;
    logic [BYTE_W-1:0] low_byte;
  } cpwm_duty_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [DUTY_W-1:0] cpwm_align(input cpwm_duty_t d, input logic left);
    logic [DUTY_W-1:0] v;
    v = left ? {d.high_byte, d.low_byte[7:6]} : {d.high_byte[1:0], d.low_byte};
    return v;
  endfunction

  function automatic cpwm_mode_t cpwm_decode(input cpwm_ctrl_t c);
    cpwm_mode_t m;
    if (!c.enable || c.mode == MODE_OFF) begin
      m = CPWM_OFF;
    end else if (c.mode[3:2] == MODE_PWM_TOP) begin
      m = CPWM_PWM;
    end else if (c.mode[3] || c.mode == MODE_TOGGLE || c.mode == MODE_TOGGLE_CLR) begin
      m = CPWM_COMPARE;
    end else begin
      m = CPWM_CAPTURE;
    end
    return m;
  endfunction

endpackage

// File: hdl/cpwm_postscaler.sv
// Timebase postscaler: divides period matches down to the wrap flag event
`timescale 1ns/100ps
module cpwm_postscaler (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  input wire logic period_match,
  input wire logic [cpwm_pkg::POST_W-1:0] postscale,
  output logic wrap_event
);
  import cpwm_pkg::*;

  logic [POST_W-1:0] count;

  function automatic logic [POST_W-1:0] post_step_add(input logic [POST_W-1:0] v);
    return POST_W'(v + POST_STEP);
  endfunction

  assign wrap_event = period_match && (count == postscale);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= POST_RESET;
    end else if (clear || wrap_event) begin
      count <= POST_RESET;
    end else if (period_match) begin
      count <= post_step_add(count);
    end
  end

endmodule // cpwm_postscaler

// File: hdl/cpwm_prescaler.sv
// Timebase prescaler: counts oscillator cycles, yields the tick and two low phase bits
`timescale 1ns/100ps
module cpwm_prescaler (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run,
  input wire logic [cpwm_pkg::PSEL_W-1:0] prescale_select,
  output logic tick,
  output logic [1:0] phase
);
  import cpwm_pkg::*;

  logic [PRE_W-1:0] count;
  logic [PRE_W-1:0] limit;
  logic [PRE_W-1:0] scaled;
  logic [PRE_W-1:0] next_count;

  // One timer step spans four oscillator cycles times the prescale ratio
  assign limit = PRE_W'((OSC_PER_INSTR << prescale_select) - PRE_ONE);
  // A count left above a lowered limit ends its step at once instead of wrapping
  assign tick = run && (count >= limit);
  assign next_count = tick ? '0 : PRE_W'(count + PRE_ONE);
  // At 1:1 these are the oscillator phase, otherwise the prescaler bits
  assign scaled = count >> prescale_select;
  assign phase = scaled[1:0];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (run) begin
      count <= next_count;
    end
  end

endmodule // cpwm_prescaler

// File: hdl/cpwm_unit.sv
// Capture/compare/PWM unit: PWM generator with timebase, compare output and sleep hold
//
// What this block does
// - Compare matching keeps working in sleep while its timer runs; can wake.
// - PWM mode drives a pulse train with up to 10-bit duty resolution.
// - Period is (period limit + 1) x 4 oscillator cycles x prescale ratio.
// - After count equals limit: clear count, set pin unless duty zero, load shadow.
// - Duty value writable anytime; takes effect only at next period match.
// - Alignment select places the 10-bit duty inside the 16-bit duty register.
// - Right: high[1:0],low[7:0]; left: high[7:0],low[7:6].
// - Time base is count plus two low bits from oscillator or prescaler.
// - Time base equal to shadow duty clears the output pin.
// - Resolution is log2(4 x (limit + 1)), full 10 bits at limit 0xff.
// - Duty beyond the period leaves the pin unchanged through the cycle.
// - Postscaler only paces the wrap flag, never the PWM frequency.
// - Sleep stops the count and freezes PWM state; in PWM mode the pin holds its level.
// - Any reset restores defaults and turns the pin to input direction.
// - Module-on bit 7 low disables all capture, compare and PWM activity.
// - Outside sleep, writing all zeros to module control forces the output latch low.
`timescale 1ns/100ps
module cpwm_unit (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sleep,
  input wire cpwm_pkg::cpwm_ctrl_t module_control,
  input wire cpwm_pkg::cpwm_tb_ctrl_t timebase_control,
  input wire logic [cpwm_pkg::TB_W-1:0] period_limit,
  input wire cpwm_pkg::cpwm_duty_t duty_compare_value,
  input wire logic [cpwm_pkg::CMP_W-1:0] compare_timer_value,
  input wire logic compare_timer_running,
  input wire logic event_flag_clear,
  input wire logic event_int_enable,
  input wire logic wrap_flag_clear,
  input wire logic pin_direction_write,
  input wire logic pin_direction_value,
  output logic unit_output_pin_o,
  output logic unit_output_pin_oe,
  output logic out_status,
  output logic [cpwm_pkg::TB_W-1:0] timebase_count,
  output logic timebase_wrap_flag,
  output logic unit_event_flag,
  output logic compare_timer_clear,
  output logic wake_request,
  output logic [cpwm_pkg::DUTY_W-1:0] duty_shadow
);
  import cpwm_pkg::*;

  // ****************************************
  // Mode decode
  // ****************************************
  cpwm_mode_t mode;
  logic pwm_active;
  logic compare_active;
  logic ctrl_zero;
  logic [DUTY_W-1:0] duty_aligned;

  assign mode = cpwm_decode(module_control);
  assign pwm_active = (mode == CPWM_PWM);
  assign compare_active = (mode == CPWM_COMPARE);
  assign ctrl_zero = (module_control == CTRL_ALL_ZERO);
  assign duty_aligned = cpwm_align(duty_compare_value, module_control.alignment_select);

  // ****************************************
  // Timebase
  // ****************************************
  logic tb_run;
  logic pre_tick;
  logic [1:0] tb_phase;
  logic period_hit;
  logic period_match;
  logic [TB_W-1:0] next_count;
  logic [DUTY_W-1:0] time_base;
  logic wrap_event;

  // Sleep gates the timebase prescaler and count so the PWM freezes in place; compare logic keeps running
  assign tb_run = timebase_control.on && !sleep;

  cpwm_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(tb_run),
    .prescale_select(timebase_control.prescale_select),
    .tick(pre_tick),
    .phase(tb_phase)
  );

  assign period_hit = (timebase_count == period_limit);
  assign period_match = pre_tick && period_hit;
  assign next_count = period_hit ? TB_RESET : TB_W'(timebase_count + TB_STEP);
  // Low two bits extend the counter so one step is one oscillator cycle times prescale
  assign time_base = {timebase_count, tb_phase};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timebase_count <= TB_RESET;
    end else if (pre_tick) begin
      timebase_count <= next_count;
    end
  end

  // Postscaler paces only the wrap flag; the PWM uses period_match directly
  cpwm_postscaler u_postscaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(!timebase_control.on),
    .period_match(period_match),
    .postscale(timebase_control.postscale),
    .wrap_event(wrap_event)
  );

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timebase_wrap_flag <= FLAG_RESET;
    end else if (wrap_event) begin
      timebase_wrap_flag <= 1'b1;
    end else if (wrap_flag_clear) begin
      timebase_wrap_flag <= 1'b0;
    end
  end

  // ****************************************
  // Duty shadow buffer
  // ****************************************
  logic load_shadow;

  // The live duty register may change anytime; only the shadow steers the pin
  assign load_shadow = pwm_active && period_match;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      duty_shadow <= DUTY_ZERO;
    end else if (load_shadow) begin
      duty_shadow <= duty_aligned;
    end
  end

  // ****************************************
  // PWM set and clear
  // ****************************************
  logic pwm_set;
  logic pwm_clear;
  logic duty_match;
  logic duty_beyond;

  // A wrapping cycle restarts at time base zero, so match is checked on the live shadow
  assign duty_match = tb_run && (time_base == duty_shadow);
  // The time base tops out at four steps per count, so a larger shadow is never reached
  assign duty_beyond = (duty_shadow[DUTY_W-1:DUTY_W-TB_W] > period_limit);
  // Pin set at period start unless the incoming duty is zero
  assign pwm_set = load_shadow && (duty_aligned != DUTY_ZERO);
  // A duty beyond the period never matches, leaving the pin as it stands
  // The registered pin falls one clock after the time base reaches the shadow
  assign pwm_clear = pwm_active && duty_match && !duty_beyond && !period_match;

  // ****************************************
  // Compare action
  // ****************************************
  logic cmp_equal;
  logic cmp_equal_d;
  logic cmp_hit;
  logic pulse_active;
  logic cmp_toggle;
  logic cmp_set;
  logic cmp_clr;
  logic cmp_pulse;
  logic cmp_clears_timer;

  // Matching does not depend on sleep, only on the compare timer still counting
  assign cmp_equal = compare_active && compare_timer_running
    && (compare_timer_value == duty_compare_value);
  assign cmp_hit = cmp_equal && !cmp_equal_d;
  assign cmp_toggle = (module_control.mode == MODE_TOGGLE)
    || (module_control.mode == MODE_TOGGLE_CLR);
  assign cmp_set = (module_control.mode == MODE_SET);
  assign cmp_clr = (module_control.mode == MODE_CLEAR);
  assign cmp_pulse = (module_control.mode == MODE_PULSE)
    || (module_control.mode == MODE_PULSE_CLR);
  assign cmp_clears_timer = (module_control.mode == MODE_TOGGLE_CLR)
    || (module_control.mode == MODE_PULSE_CLR);
  assign compare_timer_clear = cmp_hit && cmp_clears_timer;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmp_equal_d <= 1'b0;
    end else begin
      cmp_equal_d <= cmp_equal;
    end
  end

  // Pulse stays active one instruction cycle and the pin falls one clock later, so the divider runs at the 1:1 setting
  logic instr_tick;
  logic [PSEL_W-1:0] instr_select;

  assign instr_select = '0;

  cpwm_prescaler u_instr_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(pulse_active),
    .prescale_select(instr_select),
    .tick(instr_tick),
    .phase()
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulse_active <= 1'b0;
    end else if (cmp_hit && cmp_pulse) begin
      pulse_active <= 1'b1;
    end else if (instr_tick || !compare_active) begin
      pulse_active <= 1'b0;
    end
  end

  // ****************************************
  // Output latch
  // ****************************************
  logic next_latch;
  logic out_latch;
  logic pulse_done;
  logic latch_hold;

  // A pulse ends once its instruction cycle has run out
  assign pulse_done = compare_active && cmp_pulse && !pulse_active && out_latch;
  // Sleep freezes the PWM latch, but compare actions still land
  assign latch_hold = sleep && !compare_active;

  always_comb begin
    next_latch = out_latch;
    if (ctrl_zero) begin
      next_latch = LATCH_RESET;
    end else if (pwm_active) begin
      if (pwm_set) begin
        next_latch = 1'b1;
      end else if (pwm_clear) begin
        next_latch = 1'b0;
      end
    end else if (compare_active && cmp_hit) begin
      if (cmp_toggle) begin
        next_latch = !out_latch;
      end else if (cmp_set || cmp_pulse) begin
        next_latch = 1'b1;
      end else if (cmp_clr) begin
        next_latch = 1'b0;
      end
    end else if (pulse_done) begin
      next_latch = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_latch <= LATCH_RESET;
    end else if (!latch_hold) begin
      out_latch <= next_latch;
    end
  end

  // ****************************************
  // Event flag and wake
  // ****************************************
  logic unit_event;

  assign unit_event = (compare_active && cmp_hit) || load_shadow;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      unit_event_flag <= FLAG_RESET;
    end else if (unit_event) begin
      unit_event_flag <= 1'b1;
    end else if (event_flag_clear) begin
      unit_event_flag <= 1'b0;
    end
  end

  assign wake_request = sleep && unit_event_flag && event_int_enable;

  // ****************************************
  // Pin direction and drive
  // ****************************************
  logic pin_is_input;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_is_input <= DIR_RESET;
    end else if (pin_direction_write) begin
      pin_is_input <= pin_direction_value;
    end
  end

  // The latch keeps driving through sleep; in PWM mode it holds its level
  assign unit_output_pin_o = out_latch;
  assign unit_output_pin_oe = !pin_is_input;
  assign out_status = out_latch;

endmodule // cpwm_unit

// File: verif/cpwm_load.sv
// External load model: measures pulse width and period at the pin
`timescale 1ns/100ps
module cpwm_load (
  input wire logic clk_sys,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic [15:0] high_len,
  output logic [15:0] period_len
);
  logic pad;
  logic pad_q = 1'b0;
  logic [15:0] run_hi = 16'h0000;
  logic [15:0] run_per = 16'h0000;
  // Pull-down on the load keeps a released pin low
  assign pad = pin_oe ? pin_o : 1'b0;
  initial begin
    high_len = 16'h0000;
    period_len = 16'h0000;
  end
  always @(posedge clk_sys) begin
    pad_q <= pad;
    if (pad && !pad_q) begin
      period_len <= run_per;
      run_per <= 16'h0001;
      run_hi <= 16'h0001;
    end else begin
      run_per <= run_per + 16'h0001;
      if (pad) begin
        run_hi <= run_hi + 16'h0001;
      end
      if (!pad && pad_q) begin
        high_len <= run_hi;
      end
    end
  end
endmodule // cpwm_load

// File: verif/cpwm_unit_checker.sv
// Port assertions for the PWM unit
`timescale 1ns/100ps
module cpwm_unit_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sleep,
  input wire cpwm_pkg::cpwm_ctrl_t module_control,
  input wire cpwm_pkg::cpwm_tb_ctrl_t timebase_control,
  input wire logic [cpwm_pkg::TB_W-1:0] period_limit,
  input wire logic pin_direction_write,
  input wire logic pin_direction_value,
  input wire logic unit_output_pin_o,
  input wire logic unit_output_pin_oe,
  input wire logic [cpwm_pkg::TB_W-1:0] timebase_count,
  input wire logic [cpwm_pkg::DUTY_W-1:0] duty_shadow
);
  import cpwm_pkg::*;
  logic pwm;
  assign pwm = module_control.enable && module_control.mode[3:2] == MODE_PWM_TOP;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ****
  // Timebase and pin
  // ****
  sequence count_held;
    ($stable(timebase_count) || sleep) [*3];
  endsequence
  rst_defaults_a: assert property ($rose(resetn) |-> !unit_output_pin_oe &&
    !unit_output_pin_o && timebase_count == TB_RESET && duty_shadow == DUTY_ZERO)
    else $error("state after reset");
  count_wrap_a: assert property ($changed(timebase_count) &&
    $past(timebase_count) == period_limit |-> timebase_count == TB_RESET)
    else $error("count missed wrap");
  tick_gap_a: assert property ($changed(timebase_count) &&
    timebase_control.prescale_select == 3'h0 |=> count_held)
    else $error("count stepped early");
  shadow_load_a: assert property ($changed(duty_shadow) |->
    timebase_count == TB_RESET && $past(timebase_count) == period_limit)
    else $error("shadow loaded off wrap");
  pin_set_a: assert property (pwm && $rose(unit_output_pin_o) |->
    duty_shadow != DUTY_ZERO && timebase_count == TB_RESET)
    else $error("pin set off period start");
  sleep_hold_a: assert property (sleep && $past(sleep) |-> $stable(timebase_count) &&
    (!pwm || $stable(unit_output_pin_o)))
    else $error("state moved in sleep");
  off_low_a: assert property (module_control == CTRL_ALL_ZERO |=> !unit_output_pin_o)
    else $error("latch not low");
  idle_a: assert property (!module_control.enable && !$past(module_control.enable) |->
    !$rose(unit_output_pin_o) && $stable(duty_shadow))
    else $error("activity while off");
  over_hold_a: assert property (pwm && duty_shadow > {period_limit, 2'b11} &&
    $stable(duty_shadow) |-> !$fell(unit_output_pin_o))
    else $error("pin cleared past period");
  dir_load_a: assert property ($changed(unit_output_pin_oe) |->
    $past(pin_direction_write) && unit_output_pin_oe == !$past(pin_direction_value))
    else $error("driver enable moved");
endmodule // cpwm_unit_checker
bind cpwm_unit cpwm_unit_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .sleep(sleep),
  .module_control(module_control), .timebase_control(timebase_control),
  .period_limit(period_limit), .pin_direction_write(pin_direction_write),
  .pin_direction_value(pin_direction_value), .unit_output_pin_o(unit_output_pin_o),
  .unit_output_pin_oe(unit_output_pin_oe), .timebase_count(timebase_count),
  .duty_shadow(duty_shadow));

// File: verif/tb_top.sv
// Self-checking bench for the PWM unit
`timescale 1ns/100ps
module tb_top;
  import cpwm_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sleep = 1'b0;
  cpwm_ctrl_t mc = 8'h00;
  cpwm_tb_ctrl_t tc = 8'h00;
  logic [7:0] plim = 8'h00;
  cpwm_duty_t duty = 16'h0000;
  logic [15:0] ctv = 16'h0000;
  logic ctr = 1'b0;
  logic efc = 1'b0;
  logic eie = 1'b0;
  logic wfc = 1'b0;
  logic pdw = 1'b0;
  logic pdv = 1'b1;
  logic pin, oe, ost, wrap, evf, ctc, wake;
  logic [7:0] cnt;
  logic [9:0] shd;
  logic [15:0] hi, per;
  logic [8:0] keep;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;

  always #5 clk_sys = ~clk_sys;

  cpwm_unit u_dut (.clk_sys(clk_sys), .resetn(resetn), .sleep(sleep), .module_control(mc),
    .timebase_control(tc), .period_limit(plim), .duty_compare_value(duty),
    .compare_timer_value(ctv), .compare_timer_running(ctr), .event_flag_clear(efc),
    .event_int_enable(eie), .wrap_flag_clear(wfc), .pin_direction_write(pdw),
    .pin_direction_value(pdv), .unit_output_pin_o(pin), .unit_output_pin_oe(oe),
    .out_status(ost), .timebase_count(cnt), .timebase_wrap_flag(wrap),
    .unit_event_flag(evf), .compare_timer_clear(ctc), .wake_request(wake),
    .duty_shadow(shd));
  cpwm_load u_load (.clk_sys(clk_sys), .pin_o(pin), .pin_oe(oe), .high_len(hi),
    .period_len(per));

  // ****
  // Tasks
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic pdir(input logic v);
    pdv = v;
    pdw = 1'b1;
    step(1);
    pdw = 1'b0;
    step(1);
  endtask
  task automatic hold(input logic v);
    repeat (4) begin
      step(5);
      chk("pin level", pin, v);
    end
  endtask
  // Expected period and width follow from limit, prescale and buffered duty
  task automatic run_case(input logic [7:0] l, input logic [7:0] m, input logic [7:0] t,
      input logic [15:0] d, input logic [9:0] s);
    int r;
    int p;
    plim = l;
    mc = m;
    tc = t;
    duty = d;
    r = 1 << t[6:4];
    p = (l + 1) * 4 * r;
    step(3 * p + 8);
    chk("duty shadow", shd, s);
    chk("period", per, p);
    // The registered pin falls one clock after the time base reaches the duty
    chk("width", hi, s * r + 1);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ****
  // Sequence
  // ****
  initial begin
    step(20);
    resetn = 1'b1;
    step(1);
    chk("reset state", {oe, pin, cnt, shd}, 0);
    pdir(1'b1);
    plim = 8'h03;
    mc = 8'h8c;
    duty = 16'hfc06;
    wfc = 1'b1;
    step(1);
    wfc = 1'b0;
    tc = 8'h80;
    for (i = 0; i < 400 && wrap !== 1'b1; i++) step(1);
    chk("wrap flag", wrap, 1);
    pdir(1'b0);
    chk("drive", oe, 1);
    run_case(8'h03, 8'h8c, 8'h80, 16'hfc06, 10'h006);
    run_case(8'h03, 8'h9c, 8'h80, 16'h0240, 10'h009);
    run_case(8'h03, 8'h9c, 8'h9f, 16'h0240, 10'h009);
    run_case(8'h03, 8'h9c, 8'ha0, 16'h0240, 10'h009);
    mc = 8'h8c;
    tc = 8'h80;
    duty = 16'h03ff;
    step(40);
    hold(1'b1);
    duty = 16'h0000;
    step(40);
    hold(1'b0);
    duty = 16'h0006;
    step(37);
    sleep = 1'b1;
    step(2);
    keep = {pin, cnt};
    step(30);
    chk("frozen", {pin, cnt}, keep);
    sleep = 1'b0;
    mc = 8'h00;
    step(2);
    chk("latch", {ost, pin}, 0);
    mc = 8'h0c;
    step(40);
    chk("idle pin", pin, 0);
    run_case(8'hff, 8'h8c, 8'h80, 16'h03fe, 10'h3fe);
    for (i = 0; i < 2000 && cnt !== 8'h01; i++) step(1);
    duty = 16'h0011;
    step(8);
    chk("old duty", shd, 10'h3fe);
    step(1100);
    chk("new duty", shd, 10'h011);
    mc = 8'h00;
    sleep = 1'b1;
    eie = 1'b1;
    efc = 1'b1;
    step(1);
    efc = 1'b0;
    ctv = 16'h1234;
    ctr = 1'b1;
    duty = 16'h1234;
    mc = 8'h88;
    step(3);
    chk("compare", {pin, evf, wake}, 3'b111);
    ctv = 16'h0000;
    mc = 8'h8b;
    step(2);
    ctv = 16'h1234;
    #1;
    chk("timer clear", ctc, 1);
    step(1);
    chk("pulse start", pin, 1);
    step(6);
    chk("pulse end", pin, 0);
    mc = 8'h81;
    ctv = 16'h0000;
    step(1);
    ctv = 16'h1234;
    step(1);
    chk("toggle high", pin, 1);
    ctv = 16'h0000;
    step(1);
    ctv = 16'h1234;
    step(1);
    chk("toggle low", pin, 0);
    sleep = 1'b0;
    resetn = 1'b0;
    step(2);
    chk("reset again", {oe, pin, wrap, evf, cnt, shd}, 0);
    report_and_stop();
  end
endmodule // tb_top
